/* hw/awl_pkg.sv */
// package: constants for the angle word host driver
package awl_pkg;
	// angle word widths
	localparam int AWL_HI_BITS = 8;
	localparam int AWL_LO_BITS_14 = 6;
	localparam int AWL_LO_BITS_16 = 8;
	localparam int AWL_WORD_BITS = 16;
	// timing in ns and the cycle counts derived from it at 10 MHz
	localparam int AWL_CLK_NS = 100;
	localparam int AWL_SETUP_NS = 200;
	localparam int AWL_HOLD_NS = 200;
	localparam int AWL_SETUP_CYC = (AWL_SETUP_NS + AWL_CLK_NS - 1) / AWL_CLK_NS;
	localparam int AWL_HOLD_CYC = (AWL_HOLD_NS + AWL_CLK_NS - 1) / AWL_CLK_NS;
	localparam int AWL_CNT_W = 4;
	// reset values: pins idle high like the device pull-ups
	localparam logic [15:0] AWL_DATA_RST = 16'hFFFF;
	// one-hot sequencer states
	typedef enum logic [3:0] {
		AWL_IDLE = 4'h1,
		AWL_OPEN = 4'h2,
		AWL_SETL = 4'h4,
		AWL_HOLD = 4'h8
	} awl_state_e;
endpackage

/* hw/awl_cnt.sv */
// file: wait counter that flags when a programmed count is spent
module awl_cnt #(
	parameter int W = 4
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic done
);
	logic [W-1:0] cnt_ff; // cycles left
	// load takes priority, else count down to zero
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_ff <= '0;
		end else if (load) begin
			cnt_ff <= load_val;
		end else if (cnt_ff != '0) begin
			cnt_ff <= cnt_ff - 1'b1;
		end
	end
	assign done = (cnt_ff == '0) && !load;
endmodule

/* hw/awl_host.sv */
// file: host that writes angle words into the converter input latches
// Operation
// - high enable admits eight top bits
// - low enable admits six or eight bits
// - both enables open means transparent mode
// - unsigned word, top bit 180 degrees
module awl_host
	import awl_pkg::*;
#(
	parameter int ANGLE_BITS = 16
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic transparent_mode,
	input wire logic req_valid,
	input wire logic [awl_pkg::AWL_WORD_BITS-1:0] req_angle,
	output logic req_ready,
	output logic busy,
	output logic [awl_pkg::AWL_WORD_BITS-1:0] angle_out,
	output logic angle_oe_n,
	output logic high_byte_latch_enable,
	output logic low_byte_latch_enable,
	output logic enable_oe_n
);
	import awl_pkg::*;

	// low byte width and the two wait lengths for the counter
	localparam int LO_BITS = (ANGLE_BITS == 14) ? AWL_LO_BITS_14 : AWL_LO_BITS_16;
	localparam logic [AWL_CNT_W-1:0] SETUP_LD = AWL_CNT_W'(AWL_SETUP_CYC);
	localparam logic [AWL_CNT_W-1:0] HOLD_LD = AWL_CNT_W'(AWL_HOLD_CYC);

	// sequencer, pin and counter signals
	awl_state_e state_ff; // sequencer state
	awl_state_e nxt_state; // next state
	logic [AWL_WORD_BITS-1:0] data_ff; // word driven on the data pins
	logic hbe_ff; // high enable level
	logic lbe_ff; // low enable level
	logic oe_n_ff; // pin drive, low drives
	logic cnt_load; // start a wait
	logic [AWL_CNT_W-1:0] cnt_val; // wait length
	logic cnt_done; // wait spent

	// align a request word: msb-first, unused low bits of 14-bit part padded high
	function automatic logic [AWL_WORD_BITS-1:0] awl_align(input logic [AWL_WORD_BITS-1:0] a);
		logic [AWL_WORD_BITS-1:0] r;
		r = a;
		if (LO_BITS == AWL_LO_BITS_14) begin
			r[1:0] = 2'h3;
		end
		return r;
	endfunction

	// timing counter
	awl_cnt #(.W(AWL_CNT_W)) u_cnt (
		.core_clk(core_clk),
		.rst(rst),
		.load(cnt_load),
		.load_val(cnt_val),
		.done(cnt_done)
	);

	// next state and counter loads
	always_comb begin
		nxt_state = state_ff;
		cnt_load = 1'b0;
		cnt_val = SETUP_LD;
		unique case (state_ff)
			// idle: wait for a latched-mode request
			AWL_IDLE: begin
				if (req_valid && !transparent_mode) begin
					nxt_state = AWL_OPEN;
					cnt_load = 1'b1;
				end
			end
			AWL_OPEN: begin
				// both bytes presented with enables high: latch follows
				if (cnt_done) begin
					nxt_state = AWL_SETL;
				end
			end
			AWL_SETL: begin
				// enables drop together in this step
				nxt_state = AWL_HOLD;
				cnt_load = 1'b1;
				cnt_val = HOLD_LD;
			end
			// hold: keep the enables low for the hold wait
			AWL_HOLD: begin
				if (cnt_done) begin
					nxt_state = AWL_IDLE;
				end
			end
			// illegal code: recover to idle
			default: begin
				nxt_state = AWL_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff <= AWL_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// data pins: loaded when a request is taken, or follow in transparent mode
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			data_ff <= AWL_DATA_RST;
		end else if (state_ff == AWL_IDLE && req_valid) begin
			data_ff <= awl_align(req_angle);
		end
	end

	// enables: both high while transparent or presenting, both low while holding
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hbe_ff <= 1'b1;
			lbe_ff <= 1'b1;
		end else if (transparent_mode) begin
			// transparent mode: both latches stay open
			hbe_ff <= 1'b1;
			lbe_ff <= 1'b1;
		end else if (state_ff == AWL_SETL) begin
			// setup spent: close both latches in one step
			hbe_ff <= 1'b0;
			lbe_ff <= 1'b0;
		end else if (state_ff == AWL_IDLE && req_valid) begin
			// new word: open both latches while it settles
			hbe_ff <= 1'b1;
			lbe_ff <= 1'b1;
		end
	end

	// pin drive: released after reset until the first word, device pull-ups read high
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			oe_n_ff <= 1'b1;
		end else if (state_ff == AWL_IDLE && req_valid) begin
			oe_n_ff <= 1'b0;
		end
	end

	// handshake outputs from the state, pins straight from flops
	assign req_ready = (state_ff == AWL_IDLE);
	assign busy = (state_ff != AWL_IDLE);
	assign angle_out = data_ff;
	assign angle_oe_n = oe_n_ff;
	assign enable_oe_n = oe_n_ff;
	assign high_byte_latch_enable = hbe_ff;
	assign low_byte_latch_enable = lbe_ff;

	// watch the pin sequence, rule by rule

	// both enables always move as one
	AST_ENABLES_TOGETHER: assert property (@(posedge core_clk) disable iff (rst)
		hbe_ff == lbe_ff) else $error("enables differ");

	// transparent mode keeps both latches open
	AST_TRANSPARENT_HIGH: assert property (@(posedge core_clk) disable iff (rst)
		transparent_mode |=> (hbe_ff && lbe_ff)) else $error("transparent mode not high");

	// word on the pins stays put while latched
	AST_DATA_STABLE_HOLD: assert property (@(posedge core_clk) disable iff (rst)
		(state_ff == AWL_HOLD) |-> $stable(data_ff)) else $error("data moved while latched");

	// enables stay high through the setup wait
	AST_DROP_AFTER_SETUP: assert property (@(posedge core_clk) disable iff (rst)
		(state_ff == AWL_IDLE && req_valid && !transparent_mode)
		|=> (hbe_ff && lbe_ff) [*3]) else $error("enables not high during setup");

	// enables fall right after the setup wait
	AST_DROP_LOW: assert property (@(posedge core_clk) disable iff (rst || transparent_mode)
		(state_ff == AWL_SETL) |=> (!hbe_ff && !lbe_ff)) else $error("enables did not drop");

	// a taken word reaches the pins next cycle
	AST_WORD_LOADED: assert property (@(posedge core_clk) disable iff (rst)
		(state_ff == AWL_IDLE && req_valid) |=> data_ff[15:2] == $past(req_angle[15:2]))
		else $error("word not presented");

	// unused low bits of the short word read high
	AST_PAD14: assert property (@(posedge core_clk) disable iff (rst)
		(LO_BITS == AWL_LO_BITS_14 && !oe_n_ff) |-> data_ff[1:0] == 2'h3)
		else $error("unused bits not high");

	// sequence is back in idle within a short bound
	AST_DONE_BOUND: assert property (@(posedge core_clk) disable iff (rst || transparent_mode)
		(state_ff == AWL_SETL) |=> ##[1:4] (state_ff == AWL_IDLE)) else $error("hold too long");

	// pins are driven from the cycle after a take
	AST_DRIVE_ON_TAKE: assert property (@(posedge core_clk) disable iff (rst)
		(req_ready && req_valid) |=> !oe_n_ff)
		else $error("pins not driven after a take");

	// pins stay released, reading high, until the first take
	AST_RELEASED_UNTIL_TAKE: assert property (@(posedge core_clk) disable iff (rst)
		(oe_n_ff && !(req_ready && req_valid)) |=> oe_n_ff)
		else $error("pins driven before a take");

	// a request offered while busy leaves the word alone
	AST_REFUSE_BUSY: assert property (@(posedge core_clk) disable iff (rst)
		(busy && req_valid) |=> $stable(data_ff))
		else $error("request taken while busy");

	// the word stands from the second busy cycle on
	AST_DATA_HELD_BUSY: assert property (@(posedge core_clk) disable iff (rst)
		(busy && $past(busy)) |-> $stable(data_ff))
		else $error("word moved while busy");

	// setup wait: take, three open cycles, then the drop step
	AST_SETUP_SPAN: assert property (@(posedge core_clk) disable iff (rst)
		(req_ready && req_valid && !transparent_mode) |=> ##3 (state_ff == AWL_SETL))
		else $error("setup wait has the wrong length");

	// enables stay low through the hold wait, then idle follows
	AST_HOLD_LOW: assert property (@(posedge core_clk) disable iff (rst || transparent_mode)
		(state_ff == AWL_SETL) |=> (!hbe_ff && !lbe_ff) [*3] ##1 (state_ff == AWL_IDLE))
		else $error("hold wait has the wrong length");

	// both byte enables open while the word is presented
	AST_OPEN_HIGH: assert property (@(posedge core_clk) disable iff (rst)
		(state_ff == AWL_OPEN) |-> (hbe_ff && lbe_ff))
		else $error("enables closed while presenting");
endmodule

/* verif/awl_dev_model.sv */
// device model: two byte latches with pull-ups on the data and enable pins
module awl_dev_model (
	input wire logic [15:0] data_pin,
	input wire logic data_oe_n,
	input wire logic hi_en_pin,
	input wire logic lo_en_pin,
	input wire logic en_oe_n,
	output logic [15:0] latched
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] d; // data level after pull-ups
	logic he; // high enable after pull-up
	logic le; // low enable after pull-up
	assign d = data_oe_n ? 16'hFFFF : data_pin;
	assign he = en_oe_n ? 1'b1 : hi_en_pin;
	assign le = en_oe_n ? 1'b1 : lo_en_pin;
	// follow while enabled, keep last value once the enable falls
	always_latch begin
		if (he) latched[15:8] <= d[15:8];
		if (le) latched[7:0] <= d[7:0];
	end
endmodule

/* verif/tb_awl_host.sv */
// testbench for the angle word host driver
module tb_awl_host;
	timeunit 1ns;
	timeprecision 1ns;
	import awl_pkg::*;
	logic core_clk, rst, transparent_mode, req_valid, req_ready, busy;
	logic [15:0] req_angle, angle_out, latched;
	logic angle_oe_n, hi_en, lo_en, enable_oe_n;
	logic [15:0] angle_out14, latched14; // short-word copy
	logic angle_oe_n14, hi_en14, lo_en14, enable_oe_n14, req_ready14, busy14;
	int n_errors = 0;
	int n_compared = 0;
	awl_host dut (.core_clk(core_clk), .rst(rst), .transparent_mode(transparent_mode),
		.req_valid(req_valid), .req_angle(req_angle), .req_ready(req_ready), .busy(busy),
		.angle_out(angle_out), .angle_oe_n(angle_oe_n), .high_byte_latch_enable(hi_en),
		.low_byte_latch_enable(lo_en), .enable_oe_n(enable_oe_n));
	awl_dev_model dev (.data_pin(angle_out), .data_oe_n(angle_oe_n), .hi_en_pin(hi_en),
		.lo_en_pin(lo_en), .en_oe_n(enable_oe_n), .latched(latched));
	// same stimulus into a 14-bit host and its own device
	awl_host #(.ANGLE_BITS(14)) dut_14 (.core_clk(core_clk), .rst(rst),
		.transparent_mode(transparent_mode), .req_valid(req_valid), .req_angle(req_angle),
		.req_ready(req_ready14), .busy(busy14), .angle_out(angle_out14),
		.angle_oe_n(angle_oe_n14), .high_byte_latch_enable(hi_en14),
		.low_byte_latch_enable(lo_en14), .enable_oe_n(enable_oe_n14));
	awl_dev_model dev_14 (.data_pin(angle_out14), .data_oe_n(angle_oe_n14),
		.hi_en_pin(hi_en14), .lo_en_pin(lo_en14), .en_oe_n(enable_oe_n14),
		.latched(latched14));
	// clock source
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic summarize();
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask
	// wait for ready under a bounded count
	task automatic wait_ready();
		for (int i = 0; i < 20 && req_ready !== 1'b1; i++) tick();
		check(16'(req_ready), 16'h0001);
		check({14'h0, req_ready14, busy14}, 16'h0002);
	endtask
	// latched write, one extra word offered while busy must be ignored
	task automatic t_latched(input logic [15:0] w, input logic [15:0] junk);
		req_angle = w;
		req_valid = 1'b1;
		tick();
		req_valid = 1'b0;
		check(angle_out, w);
		check(latched, w);
		check({11'h0, busy, angle_oe_n, enable_oe_n, hi_en, lo_en}, 16'h0013);
		tick();
		req_angle = junk;
		req_valid = 1'b1;
		tick();
		req_valid = 1'b0;
		wait_ready();
		check(latched, w);
		check(latched14, {w[15:2], 2'h3});
		check(angle_out, w);
		check({14'h0, hi_en, lo_en}, 16'h0000);
		check({14'h0, hi_en14, lo_en14}, 16'h0000);
		repeat (3) tick();
		check(latched, w);
		check(latched14, {w[15:2], 2'h3});
	endtask
	// transparent mode, words back to back
	task automatic t_transp(input logic [15:0] a, input logic [15:0] b);
		transparent_mode = 1'b1;
		req_angle = a;
		req_valid = 1'b1;
		tick();
		check(latched, a);
		req_angle = b;
		tick();
		req_valid = 1'b0;
		repeat (2) tick();
		check(latched, b);
		check(latched14, {b[15:2], 2'h3});
		check(angle_out, b);
		check({13'h0, busy, hi_en, lo_en}, 16'h0003);
		transparent_mode = 1'b0;
	endtask
	// reset, at start and in mid-run: pins released, latches open and reading high
	task automatic t_reset();
		rst = 1'b1;
		repeat (2) tick();
		rst = 1'b0;
		check({10'h0, angle_oe_n, enable_oe_n, hi_en, lo_en, req_ready, busy}, 16'h003E);
		check(latched, 16'hFFFF);
		check(latched14, 16'hFFFF);
	endtask
	// watchdog
	initial begin
		#50000;
		n_errors++;
		summarize();
	end
	// main sequence
	initial begin
		transparent_mode = 1'b0;
		req_valid = 1'b0;
		req_angle = 16'h0000;
		t_reset();
		t_latched(16'h8001, 16'h1234);
		t_latched(16'h7FFE, 16'hFFFF);
		t_reset();
		t_transp(16'h00FF, 16'hA55A);
		t_latched(16'h0000, 16'hC3C3);
		summarize();
	end
endmodule
